// file: dv/ris_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module ris_far_side
    import ris_pkg::*;
(
    input wire logic mclk,
    input wire ris_mem_s mem,
    input wire logic irq_req,
    input wire logic rst_req,
    output logic [7:0] mem_rdata,
    output logic irq_pin_n,
    output logic rst_pin_n
);
    // Stack window stores what is pushed; other reads derive from the address
    logic [7:0] ram [0:31];
    wire logic in_stk = (mem.addr[10:5] == STK_PAGE);
    always_ff @(posedge mclk) begin
        if (mem.we & in_stk) begin
            ram[mem.addr[4:0]] <= mem.wdata;
        end
        if (mem.re) begin
            mem_rdata <= in_stk ? ram[mem.addr[4:0]] : (mem.addr[7:0] ^ 8'h5a);
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
    // Spacing of pulses is left to the bench, which holds the line until entry
    assign irq_pin_n = ~irq_req;
    assign rst_pin_n = ~rst_req;
endmodule // ris_far_side
`default_nettype wire

// file: dv/tb_reset_interrupt_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_reset_interrupt_sequencer
    import ris_pkg::*;
;
    logic mclk = 0, sys_rst = 1, irq_req = 0, boundary = 0, cmd_valid = 0;
    logic reg_we = 0, reg_re = 0, irq_pin_n, rst_pin_n, busy, core_reset, rst_req = 0;
    logic [7:0] tcount = 8'h10;
    ris_alu_s alu = '0;
    ris_rest_s restore;
    logic [7:0] acc = 8'h3c, idx = 8'hc3, reg_wdata = '0, reg_rdata, mem_rdata;
    logic [2:0] reg_addr = '0;
    logic [10:0] ip;
    logic [4:0] cc;
    ris_cmd_s cmd = '0;
    ris_mem_s mem;
    logic [18:0] wq[$];
    int fail_count = 0, n_checks = 0;
    always #4 mclk = ~mclk;
    always @(posedge mclk) if (mem.we) wq.push_back({mem.addr, mem.wdata});
    ris_sequencer dut_u (.mclk(mclk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n),
        .irq_pin_n(irq_pin_n), .boundary(boundary), .cmd_valid(cmd_valid), .cmd(cmd),
        .ip_load(1'b0), .ip_value(11'h000), .core_acc(acc), .core_idx(idx), .alu(alu),
        .timer_count(tcount), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .mem(mem), .mem_rdata(mem_rdata),
        .restore(restore), .ip(ip), .cc(cc), .busy(busy), .core_reset(core_reset));
    ris_far_side far_u (.mclk(mclk), .mem(mem), .irq_req(irq_req), .rst_req(rst_req),
        .mem_rdata(mem_rdata), .irq_pin_n(irq_pin_n), .rst_pin_n(rst_pin_n));
    function automatic logic [7:0] rom(input logic [10:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction
    function automatic logic [10:0] vec(input logic [10:0] a);
        return 11'({rom(a), rom(a + 11'h001)});
    endfunction
    task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] ex);
        n_checks++;
        if (seen !== ex) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, ex, seen);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge mclk);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge mclk);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 4000; i++) begin
            @(posedge mclk);
            #1;
            if (busy === 1'b0) break;
        end
        chk("busy", {10'h0, busy}, 11'h000);
    endtask
    // Boundary with no command: where hardware requests are looked at, unless parked in wait or stop (every cycle then)
    task automatic at_boundary();
        @(posedge mclk);
        boundary <= 1'b1;
        @(posedge mclk);
        boundary <= 1'b0;
    endtask
    task automatic t_reset();
        logic [7:0] d;
        wait_idle();
        chk("ip after reset", ip, vec(VEC_RESET));
        chk("mask bit", {10'h0, cc[CC_I]}, 11'h001);
        rd(REG_SP, d);
        chk("stack pointer", {3'h0, d}, 11'h07f);
        rd(REG_TCTL, d);
        chk("timer flags", {9'h0, d[7:6]}, 11'h001);
        $display("test reset done");
    endtask
    task automatic t_swi();
        logic [7:0] ex[5];
        ex = '{ip[7:0], {5'h0, ip[10:8]}, idx, acc, {CC_PAD, cc}};
        wq.delete();
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd <= '{OP_SWI, 11'h000};
        @(posedge mclk);
        cmd_valid <= 1'b0;
        wait_idle();
        chk("push count", 11'(wq.size()), 11'h005);
        for (int k = 0; k < 5 && k < wq.size(); k++) begin
            chk("push addr", wq[k][18:8], 11'(11'h07f - k));
            chk("push data", {3'h0, wq[k][7:0]}, {3'h0, ex[k]});
        end
        chk("soft trap vector", ip, vec(VEC_SWI));
        $display("test soft trap done");
    endtask
    task automatic t_ext();
        irq_req <= 1'b1;
        wr(REG_TCTL, 8'h80);
        at_boundary();
        repeat (3) @(posedge mclk);
        #1 chk("masked busy", {10'h0, busy}, 11'h000);
        wr(REG_CC, 8'h00);
        at_boundary();
        wait_idle();
        chk("external first", ip, vec(VEC_EXT));
        chk("mask on entry", {10'h0, cc[CC_I]}, 11'h001);
        irq_req <= 1'b0;
        $display("test external done");
    endtask
    task automatic t_timer();
        logic [7:0] d;
        wr(REG_CC, 8'h00);
        at_boundary();
        wait_idle();
        chk("timer vector", ip, vec(VEC_TMR));
        rd(REG_TCTL, d);
        chk("request kept", {10'h0, d[7]}, 11'h001);
        wr(REG_TCTL, 8'h40);
        rd(REG_TCTL, d);
        chk("request cleared", {10'h0, d[7]}, 11'h000);
        @(posedge mclk);
        tcount <= 8'h01;
        @(posedge mclk);
        tcount <= 8'h00;
        rd(REG_TCTL, d);
        chk("request on zero", {10'h0, d[7]}, 11'h001);
        $display("test timer done");
    endtask
    task automatic t_rti();
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd <= '{OP_RTI, 11'h000};
        @(posedge mclk);
        cmd_valid <= 1'b0;
        wait_idle();
        chk("restore valid", {10'h0, restore.valid}, 11'h001);
        chk("restore acc", {3'h0, restore.acc}, {3'h0, acc});
        chk("restore idx", {3'h0, restore.idx}, {3'h0, idx});
        chk("ip after return", ip, vec(VEC_EXT));
        chk("mask after return", {10'h0, cc[CC_I]}, 11'h000);
        $display("test return done");
    endtask
    task automatic t_alu();
        @(posedge mclk);
        alu <= '{1'b1, 1'b1, 1'b1, 1'b0, 8'h0f, 8'h81, 8'h90, 1'b0};
        @(posedge mclk);
        alu <= '{1'b1, 1'b1, 1'b1, 1'b0, 8'h80, 8'h80, 8'h00, 1'b1};
        #1 chk("half carry", {6'h0, cc & 5'h17}, 11'h014);
        @(posedge mclk);
        alu <= '0;
        #1 chk("zero and carry", {6'h0, cc & 5'h17}, 11'h003);
        $display("test flags done");
    endtask
    task automatic t_pin_reset();
        logic [7:0] d;
        @(posedge mclk);
        rst_req <= 1'b1;
        repeat (4) @(posedge mclk);
        rst_req <= 1'b0;
        wait_idle();
        chk("ip after pin reset", ip, vec(VEC_RESET));
        chk("flags kept", {6'h0, cc}, 11'h00b);
        rd(REG_TCTL, d);
        chk("timer after pin reset", {9'h0, d[7:6]}, 11'h001);
        rd(REG_SP, d);
        chk("stack after pin reset", {3'h0, d}, 11'h07f);
        $display("test pin reset done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (1900) @(posedge mclk);
        #1 chk("power-on hold", {10'h0, core_reset}, 11'h001);
        t_reset();
        t_swi();
        t_ext();
        t_timer();
        t_rti();
        t_alu();
        t_pin_reset();
        finish_test();
    end
    // Whole run is near 2000 cycles; this leaves ample margin before calling it a hang
    initial begin
        #100000;
        fail_count++;
        finish_test();
    end
endmodule // tb_reset_interrupt_sequencer
`default_nettype wire

// file: pkg/ris_pkg.sv
package ris_pkg;
    localparam int IP_W = 11;
    localparam logic [10:0] VEC_RESET = 11'h7fe;
    localparam logic [10:0] VEC_SWI = 11'h7fc;
    localparam logic [10:0] VEC_EXT = 11'h7fa;
    localparam logic [10:0] VEC_TMR = 11'h7f8;
    localparam logic [10:0] VEC_TMR_WAIT = 11'h7f6;
    localparam logic [10:0] VEC_NEXT = 11'h001;
    localparam logic [5:0] STK_PAGE = 6'h03;
    localparam logic [4:0] STK_TOP = 5'h1f;
    localparam logic [4:0] STK_BOTTOM = 5'h00;
    localparam logic [4:0] STK_STEP = 5'h01;
    // Power-on delay in instruction cycles; mclk is the instruction cycle
    localparam int POR_DELAY_INSTRUCTION_CYCLE = 1920;
    localparam int MCLK_PER_INSTRUCTION_CYCLE = 1;
    localparam int POR_CYCLES = POR_DELAY_INSTRUCTION_CYCLE * MCLK_PER_INSTRUCTION_CYCLE;
    localparam logic [10:0] POR_LAST = 11'(POR_CYCLES - 1);
    localparam logic [10:0] POR_ZERO = 11'h000;
    localparam logic [10:0] POR_STEP = 11'h001;
    localparam logic [7:0] TMR_ONE = 8'h01;
    localparam logic [7:0] TMR_ZERO = 8'h00;
    localparam logic [2:0] REG_CC = 3'h0;
    localparam logic [2:0] REG_TCTL = 3'h1;
    localparam logic [2:0] REG_SP = 3'h2;
    localparam logic [2:0] REG_IPL = 3'h3;
    localparam logic [2:0] REG_IPH = 3'h4;
    localparam logic [2:0] REG_STAT = 3'h5;
    localparam int TCTL_REQ = 7;
    localparam int TCTL_MASK = 6;
    localparam int CC_C = 0;
    localparam int CC_Z = 1;
    localparam int CC_N = 2;
    localparam int CC_I = 3;
    localparam int CC_H = 4;
    localparam logic [2:0] CC_PAD = 3'h7;
    localparam logic [4:0] CC_RESET = 5'h08;
    localparam logic [2:0] CALL_BYTES = 3'h2;
    localparam logic [2:0] TRAP_BYTES = 3'h5;
    localparam logic [2:0] CNT_LAST = 3'h1;
    localparam logic [2:0] SLOT_CC = 3'h0;
    localparam logic [2:0] SLOT_A = 3'h1;
    localparam logic [2:0] SLOT_X = 3'h2;
    localparam logic [2:0] SLOT_HI = 3'h3;
    localparam logic [2:0] SLOT_LO = 3'h4;
    localparam logic [2:0] SLOT_STEP = 3'h1;

    typedef enum logic [2:0] {
        OP_NONE = 3'b000, OP_CALL = 3'b001, OP_RET = 3'b010, OP_SWI = 3'b011,
        OP_RTI = 3'b100, OP_RSP = 3'b101, OP_WAIT = 3'b110, OP_STOP = 3'b111
    } ris_op_e;

    typedef enum logic [2:0] {
        ST_RESET = 3'b000, ST_RUN = 3'b001, ST_PUSH = 3'b010, ST_PULL = 3'b011,
        ST_PULL_END = 3'b100, ST_VEC_HI = 3'b101, ST_VEC_LO = 3'b110, ST_VEC_END = 3'b111
    } ris_state_e;

    typedef struct packed {
        ris_op_e op;
        logic [10:0] target;
    } ris_cmd_s;

    typedef struct packed {
        logic valid;
        logic is_add;
        logic upd_c;
        logic cin;
        logic [7:0] opa;
        logic [7:0] opb;
        logic [7:0] result;
        logic carry;
    } ris_alu_s;

    typedef struct packed {
        logic re;
        logic we;
        logic [10:0] addr;
        logic [7:0] wdata;
    } ris_mem_s;

    typedef struct packed {
        logic valid;
        logic [7:0] acc;
        logic [7:0] idx;
    } ris_rest_s;
endpackage

// file: verilog/ris_sequencer.sv
// Functional notes
// RULE_01: Instruction pointer is an 11-bit register holding the next instruction address.
// RULE_02: Stack pointer is 11 bits, upper six fixed, addresses 60 to 7F hex.
// RULE_03: Any reset or stack-reset instruction loads the stack pointer with 7F hex.
// RULE_04: After 32 pushes the pointer wraps to 7F, silently overwriting old data.
// RULE_05: A call pushes two bytes, an interrupt entry pushes five.
// RULE_06: Push low pointer byte first, then high, then the rest; pull reversed.
// RULE_07: Half carry set on carry from bit 3 into bit 4 of an add.
// RULE_08: Global mask blocks external and timer interrupts; requests stay latched meanwhile.
// RULE_09: Negative copies result bit 7, zero flags zero result, carry records carry.
// RULE_10: Power-on holds reset 1920 cycles; a low reset pin extends it.
// RULE_11: Reset clears timer request, sets timer and global masks, clears latches and directions.
// RULE_12: Reset fetches the start address from the vector pair 7FE and 7FF.
// RULE_13: Reset leaves all other state, including other registers, untouched.
// RULE_14: Interrupts never abort an instruction; they are checked at instruction boundaries.
// RULE_15: External interrupt wins over timer interrupt when both are pending.
// RULE_16: Interrupt entry stacks registers and sets the global mask; return restores them.
// RULE_17: Timer request sets when the timer count goes from 01 to 00.
// RULE_18: Timer interrupt is taken only with timer mask and global mask clear.
// RULE_19: Timer vector is 7F8/7F9, or 7F6/7F7 when waiting.
// RULE_20: Taking the timer interrupt leaves the request set until software clears it.
// RULE_21: External interrupt by low level or latched falling edge, vector 7FA/7FB.
// RULE_22: Soft trap ignores the global mask, stacks like an interrupt, vector 7FC/7FD.
// RULE_23: Trap stacking order is pointer low, pointer high, index, accumulator, flags.
// RULE_24: A request still low after return is recognised again.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ris_sequencer
    import ris_pkg::*;
#(
    parameter logic LEVEL_SENSE = 1'b1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic rst_pin_n,
    input wire logic irq_pin_n,
    input wire logic boundary,
    input wire logic cmd_valid,
    input wire ris_cmd_s cmd,
    input wire logic ip_load,
    input wire logic [10:0] ip_value,
    input wire logic [7:0] core_acc,
    input wire logic [7:0] core_idx,
    input wire ris_alu_s alu,
    input wire logic [7:0] timer_count,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    output var ris_mem_s mem,
    input wire logic [7:0] mem_rdata,
    output var ris_rest_s restore,
    output logic [10:0] ip,
    output logic [4:0] cc,
    output logic busy,
    output logic core_reset
);
    logic rst_s1, rst_s2;
    logic irq_s1, irq_s2, irq_s3;
    logic [10:0] por_cnt;
    logic por_done;
    logic in_reset;
    ris_state_e state, next_state;
    logic [2:0] cnt, slot, rd_slot;
    logic rd_vld, is_trap, is_rti;
    logic [10:0] vec_base, tgt;
    logic [7:0] a_hold, x_hold, cc_img, tmp_hi;
    logic [4:0] sp_low;
    logic [4:0] next_cc;
    logic [7:0] tmr_prev;
    logic tmr_flag, tmr_mask, ext_latch, wait_lat, stop_lat;

    // Pins are asynchronous; the second stage feeds logic, and the interrupt edge detect also uses the third
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
            irq_s1 <= 1'b1;
            irq_s2 <= 1'b1;
            irq_s3 <= 1'b1;
        end else begin
            rst_s1 <= rst_pin_n;
            rst_s2 <= rst_s1;
            irq_s1 <= irq_pin_n;
            irq_s2 <= irq_s1;
            irq_s3 <= irq_s2;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            por_cnt <= POR_ZERO;
            por_done <= 1'b0;
            in_reset <= 1'b1;
        end else begin
            if (!por_done) begin
                por_cnt <= por_cnt + POR_STEP; // [RULE_10]
            end
            por_done <= por_done | (por_cnt == POR_LAST); // [RULE_10]
            in_reset <= ~por_done | ~rst_s2; // [RULE_10]
        end
    end

    wire logic irq_fall = irq_s3 & ~irq_s2;
    wire logic wr_cc = reg_we & (reg_addr == REG_CC);
    wire logic wr_tctl = reg_we & (reg_addr == REG_TCTL);
    wire logic run = (state == ST_RUN) & ~in_reset;
    wire logic do_cmd = run & cmd_valid;
    // Level mode keeps asking while the pin is low, so a held line retriggers
    wire logic ext_req = ext_latch | (LEVEL_SENSE & ~irq_s2); // [RULE_21] [RULE_24]
    wire logic ext_go = ext_req & ~cc[CC_I]; // [RULE_08]
    wire logic tmr_go = tmr_flag & ~tmr_mask & ~cc[CC_I]; // [RULE_18]
    // Boundary with no command finishing, or any cycle while parked in low power
    wire logic check = run & ((boundary & ~cmd_valid) | wait_lat | stop_lat); // [RULE_14]
    wire logic take_ext = check & ext_go; // [RULE_15]
    wire logic take_tmr = check & ~ext_go & tmr_go; // [RULE_15]
    wire logic take_swi = do_cmd & (cmd.op == OP_SWI); // [RULE_22]
    wire logic ent_trap = take_ext | take_tmr | take_swi;
    wire logic ent_call = do_cmd & (cmd.op == OP_CALL);
    wire logic ent_pull = do_cmd & ((cmd.op == OP_RET) | (cmd.op == OP_RTI));
    wire logic tmr_vec_sel = wait_lat;
    wire logic [10:0] tmr_vec = tmr_vec_sel ? VEC_TMR_WAIT : VEC_TMR; // [RULE_19]
    wire logic [10:0] trap_vec = take_ext ? VEC_EXT : (take_tmr ? tmr_vec : VEC_SWI); // [RULE_21]
    wire logic tmr_set = (tmr_prev == TMR_ONE) & (timer_count == TMR_ZERO); // [RULE_17]
    wire logic [4:0] half_sum = {1'b0, alu.opa[3:0]} + {1'b0, alu.opb[3:0]} + {4'h0, alu.cin};
    wire logic [4:0] sp_dec = sp_low - STK_STEP;
    wire logic [4:0] sp_inc = sp_low + STK_STEP;
    wire logic [10:0] stk_addr = (state == ST_PULL) ? {STK_PAGE, sp_inc} : {STK_PAGE, sp_low}; // [RULE_02]
    wire logic last = (cnt == CNT_LAST);
    // Trap order on the way down: pointer low, high, index, accumulator, flags
    wire logic [7:0] push_byte = (slot == SLOT_LO) ? ip[7:0] :
                                 (slot == SLOT_HI) ? {5'h00, ip[10:8]} :
                                 (slot == SLOT_X) ? x_hold :
                                 (slot == SLOT_A) ? a_hold : cc_img; // [RULE_06] [RULE_23]
    wire logic cap_cc = rd_vld & (rd_slot == SLOT_CC);

    always_comb begin
        next_state = state;
        case (state)
            ST_RESET: next_state = ST_VEC_HI;
            ST_RUN: begin
                if (ent_trap | ent_call) begin
                    next_state = ST_PUSH;
                end else if (ent_pull) begin
                    next_state = ST_PULL;
                end
            end
            ST_PUSH: next_state = last ? (is_trap ? ST_VEC_HI : ST_RUN) : ST_PUSH;
            ST_PULL: next_state = last ? ST_PULL_END : ST_PULL;
            ST_PULL_END: next_state = ST_RUN;
            ST_VEC_HI: next_state = ST_VEC_LO;
            ST_VEC_LO: next_state = ST_VEC_END;
            ST_VEC_END: next_state = ST_RUN;
            default: next_state = ST_RESET;
        endcase
        if (in_reset) begin
            next_state = ST_RESET; // [RULE_12]
        end
    end

    assign mem = '{re: (state == ST_PULL) | (state == ST_VEC_HI) | (state == ST_VEC_LO),
                   we: (state == ST_PUSH),
                   addr: (state == ST_VEC_HI) ? vec_base :
                         (state == ST_VEC_LO) ? vec_base + VEC_NEXT : stk_addr,
                   wdata: (state == ST_PUSH) ? push_byte : 8'h00};
    assign busy = (state != ST_RUN) | in_reset;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_RESET;
            cnt <= 3'h0;
            slot <= SLOT_CC;
            is_trap <= 1'b0;
            is_rti <= 1'b0;
            vec_base <= VEC_RESET;
            tgt <= 11'h000;
            a_hold <= 8'h00;
            x_hold <= 8'h00;
            cc_img <= 8'h00;
        end else begin
            state <= next_state;
            if (state == ST_RESET) begin
                vec_base <= VEC_RESET; // [RULE_12]
            end else if (ent_trap | ent_call) begin
                cnt <= ent_call ? CALL_BYTES : TRAP_BYTES; // [RULE_05]
                slot <= SLOT_LO; // [RULE_06]
                is_trap <= ent_trap;
                vec_base <= trap_vec;
                tgt <= cmd.target;
                a_hold <= core_acc;
                x_hold <= core_idx;
                cc_img <= {CC_PAD, cc}; // [RULE_16]
            end else if (ent_pull) begin
                cnt <= (cmd.op == OP_RTI) ? TRAP_BYTES : CALL_BYTES; // [RULE_05]
                slot <= (cmd.op == OP_RTI) ? SLOT_CC : SLOT_HI; // [RULE_06] [RULE_23]
                is_rti <= (cmd.op == OP_RTI);
            end else if (state == ST_PUSH) begin
                cnt <= cnt - CNT_LAST;
                slot <= slot - SLOT_STEP;
            end else if (state == ST_PULL) begin
                cnt <= cnt - CNT_LAST;
                slot <= slot + SLOT_STEP;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_vld <= 1'b0;
            rd_slot <= SLOT_CC;
            tmp_hi <= 8'h00;
            restore <= '0;
        end else begin
            rd_vld <= (state == ST_PULL);
            rd_slot <= slot;
            if ((state == ST_VEC_LO) | (rd_vld & (rd_slot == SLOT_HI))) begin
                tmp_hi <= mem_rdata;
            end
            if (rd_vld & (rd_slot == SLOT_A)) begin
                restore.acc <= mem_rdata; // [RULE_16]
            end
            if (rd_vld & (rd_slot == SLOT_X)) begin
                restore.idx <= mem_rdata; // [RULE_16]
            end
            restore.valid <= (state == ST_PULL_END) & is_rti & ~in_reset;
        end
    end

    // Stack window is only five bits wide; overflow wraps with no warning
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sp_low <= STK_TOP;
        end else if (in_reset | (do_cmd & (cmd.op == OP_RSP))) begin
            sp_low <= STK_TOP; // [RULE_03]
        end else if (state == ST_PUSH) begin
            sp_low <= sp_dec; // [RULE_04]
        end else if (state == ST_PULL) begin
            sp_low <= sp_inc;
        end
    end

    // Only sys_rst touches the pointer (loads 000); pin and power-on reset leave it, and the vector fetch overwrites it later
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ip <= 11'h000;
        end else if ((state == ST_VEC_END) | (state == ST_PULL_END)) begin
            ip <= {tmp_hi[2:0], mem_rdata}; // [RULE_01] [RULE_13]
        end else if ((state == ST_PUSH) & last & ~is_trap) begin
            ip <= tgt;
        end else if (run & ip_load & ~ent_trap) begin
            ip <= ip_value; // [RULE_01]
        end
    end

    always_comb begin
        next_cc = cc;
        if (alu.valid & run) begin
            next_cc[CC_N] = alu.result[7]; // [RULE_09]
            next_cc[CC_Z] = (alu.result == 8'h00); // [RULE_09]
            if (alu.upd_c) begin
                next_cc[CC_C] = alu.carry; // [RULE_09]
            end
            if (alu.is_add) begin
                next_cc[CC_H] = half_sum[4]; // [RULE_07]
            end
        end
        if (wr_cc) begin
            next_cc = reg_wdata[4:0];
        end
        if (cap_cc) begin
            next_cc = mem_rdata[4:0]; // [RULE_16]
        end
        if (do_cmd & ((cmd.op == OP_WAIT) | (cmd.op == OP_STOP))) begin
            next_cc[CC_I] = 1'b0;
        end
        if (ent_trap) begin
            next_cc[CC_I] = 1'b1; // [RULE_16]
        end
        if (in_reset) begin
            next_cc[CC_I] = 1'b1; // [RULE_11]
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cc <= CC_RESET;
        end else begin
            cc <= next_cc;
        end
    end

    // A count hitting zero in the same cycle as a software clear still sets
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tmr_prev <= TMR_ZERO;
            tmr_flag <= 1'b0;
            tmr_mask <= 1'b1;
        end else begin
            tmr_prev <= timer_count;
            if (in_reset | (do_cmd & (cmd.op == OP_STOP))) begin
                tmr_flag <= 1'b0; // [RULE_11]
                tmr_mask <= 1'b1; // [RULE_11]
            end else begin
                tmr_flag <= tmr_set | (wr_tctl ? reg_wdata[TCTL_REQ] : tmr_flag); // [RULE_17] [RULE_20]
                tmr_mask <= wr_tctl ? reg_wdata[TCTL_MASK] : tmr_mask;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_latch <= 1'b0;
            wait_lat <= 1'b0;
            stop_lat <= 1'b0;
        end else if (in_reset) begin
            ext_latch <= 1'b0; // [RULE_11]
            wait_lat <= 1'b0; // [RULE_11]
            stop_lat <= 1'b0; // [RULE_11]
        end else begin
            ext_latch <= irq_fall | (ext_latch & ~take_ext); // [RULE_08] [RULE_21]
            wait_lat <= (wait_lat & ~ent_trap) | (do_cmd & (cmd.op == OP_WAIT));
            stop_lat <= (stop_lat & ~ent_trap) | (do_cmd & (cmd.op == OP_STOP));
        end
    end

    // Port direction bits live in the core; this level only drives core_reset from in_reset, and the core clears them
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            core_reset <= 1'b1;
        end else begin
            core_reset <= in_reset; // [RULE_11]
        end
    end

    wire logic [7:0] rd_mux = (reg_addr == REG_CC) ? {CC_PAD, cc} :
                              (reg_addr == REG_TCTL) ? {tmr_flag, tmr_mask, 6'h00} :
                              (reg_addr == REG_SP) ? {STK_PAGE[2:0], sp_low} :
                              (reg_addr == REG_IPL) ? ip[7:0] :
                              (reg_addr == REG_IPH) ? {5'h00, ip[10:8]} :
                              (reg_addr == REG_STAT) ?
                                  {4'h0, in_reset, ext_latch, stop_lat, wait_lat} : 8'h00;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_re ? rd_mux : 8'h00;
        end
    end

    property p_stack_window;
        @(posedge mclk) disable iff (sys_rst)
        ((state == ST_PUSH) | (state == ST_PULL)) |-> (mem.addr[10:5] == STK_PAGE);
    endproperty
    a_stack_window: assert property (p_stack_window) else $error("stack outside window"); // [RULE_02]

    property p_sp_reset;
        @(posedge mclk) disable iff (sys_rst)
        in_reset |=> (sp_low == STK_TOP);
    endproperty
    a_sp_reset: assert property (p_sp_reset) else $error("sp not at top in reset"); // [RULE_03]

    property p_wrap;
        @(posedge mclk) disable iff (sys_rst)
        ((state == ST_PUSH) & (sp_low == STK_BOTTOM) & ~in_reset) |=> (sp_low == STK_TOP);
    endproperty
    a_wrap: assert property (p_wrap) else $error("stack did not wrap"); // [RULE_04]

    property p_por_hold;
        @(posedge mclk) disable iff (sys_rst)
        !por_done |=> in_reset;
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("left reset early"); // [RULE_10]

    property p_reset_vec;
        @(posedge mclk) disable iff (sys_rst)
        $fell(in_reset) |-> ##[1:2] (mem.re & (mem.addr == VEC_RESET));
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("no reset vector fetch"); // [RULE_12]

    property p_tmr_set;
        @(posedge mclk) disable iff (sys_rst)
        (tmr_set & ~in_reset & ~do_cmd) |=> tmr_flag;
    endproperty
    a_tmr_set: assert property (p_tmr_set) else $error("timer request not set"); // [RULE_17]

    property p_tmr_keep;
        @(posedge mclk) disable iff (sys_rst)
        (take_tmr & ~wr_tctl) |=> (tmr_flag & (state == ST_PUSH)) [*2];
    endproperty
    a_tmr_keep: assert property (p_tmr_keep) else $error("timer request lost on entry"); // [RULE_20]

    property p_masked;
        @(posedge mclk) disable iff (sys_rst)
        cc[CC_I] |-> !(take_ext | take_tmr);
    endproperty
    a_masked: assert property (p_masked) else $error("interrupt taken while masked"); // [RULE_08]

    property p_prio;
        @(posedge mclk) disable iff (sys_rst)
        (check & ext_go & tmr_go) |=> (vec_base == VEC_EXT) ##5 (mem.addr == VEC_EXT);
    endproperty
    a_prio: assert property (p_prio) else $error("timer beat external"); // [RULE_15]

    property p_half;
        @(posedge mclk) disable iff (sys_rst)
        (alu.valid & alu.is_add & run & ~wr_cc) |=> (cc[CC_H] == $past(half_sum[4]));
    endproperty
    a_half: assert property (p_half) else $error("half carry wrong"); // [RULE_07]

    property p_entry_mask;
        @(posedge mclk) disable iff (sys_rst)
        (ent_trap & ~in_reset) |=> cc[CC_I] & (cc_img[CC_I] == $past(cc[CC_I]));
    endproperty
    a_entry_mask: assert property (p_entry_mask) else $error("entry did not mask"); // [RULE_16]

    property p_swi;
        @(posedge mclk) disable iff (sys_rst)
        take_swi |=> (state == ST_PUSH) & (vec_base == VEC_SWI);
    endproperty
    a_swi: assert property (p_swi) else $error("soft trap not taken"); // [RULE_22]
endmodule // ris_sequencer
`default_nettype wire
